// >>> core/timer8_pkg.sv
package timer8_pkg;

  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CMP_A = 8'h08;
  localparam logic [7:0] OFS_CMP_B = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_FORCE = 8'h14;
  localparam logic [7:0] OFS_PORT = 8'h18;

  localparam int CTRL_ACT_A_LSB = 0;
  localparam int CTRL_ACT_B_LSB = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  localparam int FORCE_A = 0;
  localparam int FORCE_B = 1;
  localparam int PORT_OUT_A = 0;
  localparam int PORT_DIR_A = 1;
  localparam int PORT_OUT_B = 2;
  localparam int PORT_DIR_B = 3;
  localparam int PORT_OC_A = 4;
  localparam int PORT_OC_B = 5;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [3:0] PORT_RESET = 4'h0;
  localparam logic OC_RESET = 1'b0;

  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_PHASE_MAX = 3'b001,
    MODE_CLEAR_ON_MATCH = 3'b010,
    MODE_FAST_MAX = 3'b011,
    MODE_RSVD4 = 3'b100,
    MODE_PHASE_CMP = 3'b101,
    MODE_RSVD6 = 3'b110,
    MODE_FAST_CMP = 3'b111
  } waveform_mode_t;

  function automatic logic is_fast_pwm(input waveform_mode_t m);
    return (m == MODE_FAST_MAX) || (m == MODE_FAST_CMP);
  endfunction

  function automatic logic top_is_compare(input waveform_mode_t m);
    return (m == MODE_CLEAR_ON_MATCH) || (m == MODE_FAST_CMP);
  endfunction

endpackage

// >>> core/timer8_counter.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_counter
  import timer8_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire waveform_mode_t waveform_mode_select,
  input wire logic [7:0] compare_a_active,
  input wire logic count_wr,
  input wire logic [7:0] count_wdata,
  output logic [7:0] timer_count,
  output logic match_enable,
  output logic bottom_event,
  output logic overflow_set
);

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic block_q;
  logic fast;
  logic [7:0] top_value;
  logic at_top;
  logic wrap;

  assign fast = is_fast_pwm(waveform_mode_select);
  assign top_value = top_is_compare(waveform_mode_select) ?
                     compare_a_active : COUNT_MAX;
  assign at_top = (count_q == top_value);
  // Clear-on-match clear is a compare match, so a blocked cycle skips it
  assign wrap = at_top && (fast || !block_q);
  assign match_enable = timer_tick && !block_q;
  assign bottom_event = timer_tick && !count_wr && fast && at_top;
  assign overflow_set = timer_tick && !count_wr &&
                        (fast ? at_top : (count_q == COUNT_MAX));
  assign timer_count = count_q;

  always_comb begin
    count_d = count_q;
    if (count_wr) begin
      count_d = count_wdata;
    end else if (timer_tick) begin
      if (wrap) begin
        count_d = COUNT_BOTTOM;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= COUNT_BOTTOM;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

  // Block lasts until the next timer tick, even while the timer is stopped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else if (clk_en) begin
      if (count_wr) begin
        block_q <= 1'b1;
      end else if (timer_tick) begin
        block_q <= 1'b0;
      end
    end
  end

endmodule // timer8_counter
`default_nettype wire

// >>> core/timer8_compare_channel.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_channel
  import timer8_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic fast_pwm,
  input wire logic toggle_in_pwm,
  input wire logic [1:0] output_action_select,
  input wire logic cmp_wr,
  input wire logic [7:0] cmp_wdata,
  input wire logic [7:0] timer_count,
  input wire logic match_enable,
  input wire logic bottom_event,
  input wire logic force_compare_strobe,
  input wire logic port_out,
  input wire logic output_pin_direction,
  output logic [7:0] compare_buffer,
  output logic [7:0] compare_value,
  output logic compare_output,
  output logic match_set,
  output logic pin_out,
  output logic pin_oe
);

  logic [7:0] buf_q;
  logic [7:0] act_q;
  logic oc_q;
  logic oc_d;
  logic pin_q;
  logic hit;

  assign hit = match_enable && (timer_count == act_q);
  assign match_set = hit;
  assign compare_buffer = buf_q;
  assign compare_value = act_q;
  assign compare_output = oc_q;
  assign pin_out = pin_q;
  assign pin_oe = output_pin_direction;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buf_q <= CMP_RESET;
      act_q <= CMP_RESET;
    end else if (clk_en) begin
      if (cmp_wr) begin
        buf_q <= cmp_wdata;
      end
      if (!fast_pwm) begin
        act_q <= cmp_wr ? cmp_wdata : buf_q;
      end else if (bottom_event) begin
        act_q <= buf_q;
      end
    end
  end

  // Action is read live, never buffered with the compare value
  always_comb begin
    oc_d = oc_q;
    if (!fast_pwm) begin
      if (hit || force_compare_strobe) begin
        case (output_action_select)
          ACT_TOGGLE: oc_d = !oc_q;
          ACT_CLEAR: oc_d = 1'b0;
          ACT_SET: oc_d = 1'b1;
          default: oc_d = oc_q;
        endcase
      end
    end else begin
      case (output_action_select)
        ACT_TOGGLE: begin
          if (hit && toggle_in_pwm) begin
            oc_d = !oc_q;
          end
        end
        // Bottom wins, so a compare at TOP gives a constant level
        ACT_CLEAR: begin
          if (bottom_event) begin
            oc_d = 1'b1;
          end else if (hit) begin
            oc_d = 1'b0;
          end
        end
        ACT_SET: begin
          if (bottom_event) begin
            oc_d = 1'b0;
          end else if (hit) begin
            oc_d = 1'b1;
          end
        end
        default: oc_d = oc_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      oc_q <= OC_RESET;
      pin_q <= 1'b0;
    end else if (clk_en) begin
      oc_q <= oc_d;
      pin_q <= (output_action_select != ACT_OFF) ? oc_q : port_out;
    end
  end

endmodule // timer8_compare_channel
`default_nettype wire

// >>> core/timer8_waveform_generator.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_waveform_generator
  import timer8_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic overflow_flag,
  output logic compare_a_flag,
  output logic compare_b_flag,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);

  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic wr_ok;
  logic ar_take;
  logic [7:0] ctrl_q;
  logic [2:0] flags_q;
  logic [3:0] port_q;
  logic count_wr;
  logic cmp_a_wr;
  logic cmp_b_wr;
  logic flags_wr;
  logic force_a;
  logic force_b;
  waveform_mode_t mode;
  logic fast;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic [7:0] timer_count;
  logic match_enable;
  logic bottom_event;
  logic overflow_set;
  logic [7:0] buf_a;
  logic [7:0] buf_b;
  logic [7:0] active_a;
  logic match_a;
  logic match_b;
  logic [7:0] rd_value;
  logic rd_hit;

  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_COUNT) || (a == OFS_CMP_A) ||
           (a == OFS_CMP_B) || (a == OFS_FLAGS) || (a == OFS_FORCE) ||
           (a == OFS_PORT);
  endfunction

  // Low address bits are ignored, so every access lands on a whole word
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // Write channel: address and data taken in either order, one at a time
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_ok = do_write && w_lane_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= word_addr(s_axi_awaddr);
      end else if (do_write) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Write side effects, only when byte lane 0 is enabled
  assign count_wr = wr_ok && (aw_addr_q == OFS_COUNT);
  assign cmp_a_wr = wr_ok && (aw_addr_q == OFS_CMP_A);
  assign cmp_b_wr = wr_ok && (aw_addr_q == OFS_CMP_B);
  assign flags_wr = wr_ok && (aw_addr_q == OFS_FLAGS);
  assign force_a = wr_ok && (aw_addr_q == OFS_FORCE) && w_data_q[FORCE_A];
  assign force_b = wr_ok && (aw_addr_q == OFS_FORCE) && w_data_q[FORCE_B];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (clk_en) begin
      if (wr_ok && (aw_addr_q == OFS_CTRL)) begin
        ctrl_q <= {1'b0, w_data_q[6:0]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_q <= PORT_RESET;
    end else if (clk_en) begin
      if (wr_ok && (aw_addr_q == OFS_PORT)) begin
        port_q <= w_data_q[3:0];
      end
    end
  end

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= FLAGS_RESET;
    end else if (clk_en) begin
      flags_q[FLAG_OVF] <= (flags_q[FLAG_OVF] &&
        !(flags_wr && w_data_q[FLAG_OVF])) || overflow_set;
      flags_q[FLAG_CMP_A] <= (flags_q[FLAG_CMP_A] &&
        !(flags_wr && w_data_q[FLAG_CMP_A])) || match_a;
      flags_q[FLAG_CMP_B] <= (flags_q[FLAG_CMP_B] &&
        !(flags_wr && w_data_q[FLAG_CMP_B])) || match_b;
    end
  end

  assign mode = waveform_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
  assign act_a = ctrl_q[CTRL_ACT_A_LSB +: 2];
  assign act_b = ctrl_q[CTRL_ACT_B_LSB +: 2];
  assign fast = is_fast_pwm(mode);

  // Read channel
  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rd_hit = mapped(word_addr(s_axi_araddr));

  always_comb begin
    rd_value = 8'h00;
    case (word_addr(s_axi_araddr))
      OFS_CTRL: rd_value = ctrl_q;
      OFS_COUNT: rd_value = timer_count;
      OFS_CMP_A: rd_value = buf_a;
      OFS_CMP_B: rd_value = buf_b;
      OFS_FLAGS: rd_value = {5'h00, flags_q};
      OFS_PORT: rd_value = {2'b00, compare_output_b, compare_output_a,
                            port_q};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (clk_en) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= {24'h000000, rd_value};
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  timer8_counter u_counter (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .timer_tick(timer_tick),
    .waveform_mode_select(mode),
    .compare_a_active(active_a),
    .count_wr(count_wr),
    .count_wdata(w_data_q),
    .timer_count(timer_count),
    .match_enable(match_enable),
    .bottom_event(bottom_event),
    .overflow_set(overflow_set)
  );

  timer8_compare_channel u_chan_a (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .fast_pwm(fast),
    .toggle_in_pwm(mode == MODE_FAST_CMP),
    .output_action_select(act_a),
    .cmp_wr(cmp_a_wr),
    .cmp_wdata(w_data_q),
    .timer_count(timer_count),
    .match_enable(match_enable),
    .bottom_event(bottom_event),
    .force_compare_strobe(force_a && !fast),
    .port_out(port_q[PORT_OUT_A]),
    .output_pin_direction(port_q[PORT_DIR_A]),
    .compare_buffer(buf_a),
    .compare_value(active_a),
    .compare_output(compare_output_a),
    .match_set(match_a),
    .pin_out(pin_a_out),
    .pin_oe(pin_a_oe)
  );

  // Channel B has no TOP role; its value never reaches the counter
  timer8_compare_channel u_chan_b (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .fast_pwm(fast),
    .toggle_in_pwm(mode == MODE_FAST_CMP),
    .output_action_select(act_b),
    .cmp_wr(cmp_b_wr),
    .cmp_wdata(w_data_q),
    .timer_count(timer_count),
    .match_enable(match_enable),
    .bottom_event(bottom_event),
    .force_compare_strobe(force_b && !fast),
    .port_out(port_q[PORT_OUT_B]),
    .output_pin_direction(port_q[PORT_DIR_B]),
    .compare_buffer(buf_b),
    .compare_value(),
    .compare_output(compare_output_b),
    .match_set(match_b),
    .pin_out(pin_b_out),
    .pin_oe(pin_b_oe)
  );

  assign overflow_flag = flags_q[FLAG_OVF];
  assign compare_a_flag = flags_q[FLAG_CMP_A];
  assign compare_b_flag = flags_q[FLAG_CMP_B];

endmodule // timer8_waveform_generator
`default_nettype wire

// >>> tb/timer8_wg_props.sv
`timescale 1ns/1ps
`default_nettype none
module timer8_wg_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic timer_tick,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_output_a,
  input wire logic overflow_flag,
  input wire logic compare_a_flag,
  input wire logic pin_a_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Flags only rise on a running tick; software writes are the sole clear
  property p_ovf_rise;
    $rose(overflow_flag) |-> $past(timer_tick) && $past(clk_en);
  endproperty
  a_ovf_rise: assert property (p_ovf_rise)
    else $error("overflow flag rose without a tick");
  property p_ovf_hold;
    $fell(overflow_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag cleared without a write");
  property p_cmp_rise;
    $rose(compare_a_flag) |-> $past(timer_tick) && $past(clk_en);
  endproperty
  a_cmp_rise: assert property (p_cmp_rise)
    else $error("compare flag rose without a tick");
  property p_cmp_hold;
    $fell(compare_a_flag) |-> $rose(s_axi_bvalid);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold)
    else $error("compare flag cleared without a write");
  property p_oc_cause;
    $changed(compare_output_a) |-> $past(timer_tick) || $rose(s_axi_bvalid);
  endproperty
  a_oc_cause: assert property (p_oc_cause)
    else $error("compare output moved without match or force");
  property p_oe_cause;
    $changed(pin_a_oe) |-> $rose(s_axi_bvalid);
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("pin enable moved without a write");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");
  property p_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("write taken while response pending");
endmodule // timer8_wg_props
bind timer8_waveform_generator timer8_wg_props timer8_wg_props_inst (.*);
`default_nettype wire

// >>> tb/pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input wire logic ref_clk,
  input wire logic drv,
  input wire logic oe,
  output logic level
);
  logic last_q = 1'b0;
  // No pull on this net, so a released pin shows the inverse of its last value
  always_ff @(posedge ref_clk) begin
    if (oe) begin
      last_q <= drv;
    end
  end
  assign level = oe ? drv : ~last_q;
endmodule // pin_load
`default_nettype wire

// >>> tb/test_timer8_waveform_generator.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer8_waveform_generator import timer8_pkg::*;;
  logic ref_clk = 1'b0, reset_n = 1'b0, tick = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, r, c;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, oc_a, pa, pae, lvl;
  logic ovf, cmpf, cmpbf;
  logic [1:0] bresp, rresp;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] s;} note_t;
  note_t notes[$];
  note_t n;
  logic [1:0] resps[$];
  int fail_count = 0, samples_checked = 0, cycles = 0;
  logic [1:0] acts [4] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_OFF};
  logic ocs [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  always #4 ref_clk = ~ref_clk;
  timer8_waveform_generator timer8_waveform_generator_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .timer_tick(tick),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .compare_output_a(oc_a), .compare_output_b(),
    .overflow_flag(ovf), .compare_a_flag(cmpf), .compare_b_flag(cmpbf),
    .pin_a_out(pa), .pin_a_oe(pae), .pin_b_out(), .pin_b_oe());
  pin_load pin_load_inst (.ref_clk(ref_clk), .drv(pa), .oe(pae), .level(lvl));
  task tally_and_finish;
    $display("compared %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d,
          input logic [1:0] s = RESP_OKAY);
    logic aw, w, b;
    resps.push_back(s);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge ref_clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid === 1'b1;
      @(posedge ref_clk);
      awvalid <= awvalid && !aw;
      wvalid <= wvalid && !w;
    end
    bready <= 1'b0;
  endtask
  // Expected value is queued first; the monitor below pairs it with the answer
  task rd(input logic [7:0] a, input logic [7:0] d,
          input logic [1:0] s = RESP_OKAY);
    logic ar, rv;
    notes.push_back({a, {24'h0, d}, s});
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    while (!rv) begin
      @(negedge ref_clk);
      ar = arvalid && arready;
      rv = rvalid === 1'b1;
      @(posedge ref_clk);
      arvalid <= arvalid && !ar;
    end
    rready <= 1'b0;
  endtask
  task ticks(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      tick <= 1'b1;
    end
    @(posedge ref_clk);
    tick <= 1'b0;
  endtask
  task seeoc(input logic e);
    @(negedge ref_clk);
    chk("compare_output_a", {31'h0, e}, {31'h0, oc_a});
  endtask
  always @(negedge ref_clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      n = notes.pop_front();
      chk($sformatf("rdata at %h", n.a), n.d, rdata);
      chk($sformatf("rresp at %h", n.a), {30'h0, n.s}, {30'h0, rresp});
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk("bresp", {30'h0, resps.pop_front()}, {30'h0, bresp});
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h0DEC9FD6));
    r = 8'(1 + $urandom % 20);
    c = 8'(8 + $urandom % 90);
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(OFS_CTRL, 8'h00);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_PORT, 8'h00);
    wr(8'h1C, 8'hFF, RESP_SLVERR);
    rd(8'h1C, 8'h00, RESP_SLVERR);
    rd(OFS_CTRL, 8'h00);
    $display("test reset done");
    wr(OFS_COUNT, 8'hFE);
    ticks(1);
    rd(OFS_COUNT, 8'hFF);
    rd(OFS_FLAGS, 8'h00);
    ticks(1);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_FLAGS, 8'h01);
    wr(OFS_FLAGS, 8'h01);
    rd(OFS_FLAGS, 8'h00);
    $display("test free-running done");
    wr(OFS_CTRL, 8'h21);
    wr(OFS_CMP_A, r);
    wr(OFS_COUNT, r);
    ticks(1);
    rd(OFS_COUNT, r + 8'h01);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_COUNT, 8'h00);
    ticks(r + 1);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_FLAGS, 8'h02);
    seeoc(1'b1);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_COUNT, 8'h05);
    wr(OFS_CMP_A, 8'h02);
    ticks(251);
    rd(OFS_COUNT, 8'h00);
    rd(OFS_FLAGS, 8'h01);
    ticks(3);
    rd(OFS_FLAGS, 8'h07);
    seeoc(1'b0);
    $display("test clear-on-match done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, {6'h0, acts[i]});
      wr(OFS_FORCE, 8'h01);
      seeoc(ocs[i]);
    end
    // Output state is settled before the driver is enabled
    wr(OFS_PORT, 8'h02);
    @(negedge ref_clk);
    chk("pin level", 32'h0, {31'h0, lvl});
    chk("pin_a_oe", 32'h1, {31'h0, pae});
    wr(OFS_CTRL, {6'h0, ACT_TOGGLE});
    @(negedge ref_clk);
    chk("pin level", 32'h1, {31'h0, lvl});
    wr(OFS_CTRL, 8'h30);
    rd(OFS_PORT, 8'h12);
    $display("test force and pin done");
    wr(OFS_CTRL, {6'h0, ACT_CLEAR});
    wr(OFS_FORCE, 8'h01);
    wr(OFS_CMP_A, c);
    wr(OFS_CTRL, 8'h32);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_COUNT, 8'hFF);
    ticks(1);
    rd(OFS_COUNT, 8'h00);
    seeoc(1'b1);
    wr(OFS_CMP_A, c - 8'h04);
    rd(OFS_CMP_A, c - 8'h04);
    ticks(c);
    seeoc(1'b1);
    ticks(1);
    seeoc(1'b0);
    rd(OFS_FLAGS, 8'h07);
    $display("test fast pwm done");
    wr(OFS_CMP_A, 8'h03);
    wr(OFS_CTRL, 8'h71);
    wr(OFS_COUNT, c);
    wr(OFS_FLAGS, 8'h07);
    ticks(1);
    @(negedge ref_clk);
    chk("overflow_flag", 32'h1, {31'h0, ovf});
    chk("compare_a_flag", 32'h0, {31'h0, cmpf});
    ticks(4);
    rd(OFS_COUNT, 8'h00);
    seeoc(1'b1);
    chk("compare_a_flag", 32'h1, {31'h0, cmpf});
    chk("compare_b_flag", 32'h1, {31'h0, cmpbf});
    ticks(4);
    seeoc(1'b0);
    wr(OFS_CTRL, 8'h32);
    wr(OFS_CMP_A, 8'hFF);
    wr(OFS_COUNT, 8'hFF);
    ticks(257);
    seeoc(1'b1);
    $display("test compare top done");
    tally_and_finish();
  end
endmodule // test_timer8_waveform_generator
`default_nettype wire
